// *** rtl/ivc_defs.svh ***
// Constants of the input volume and level-control mode block
// Summary of operation
// - Disabling level control ramps back to manual gains
// - All enables clear means manual per-channel gains
// - Code F1H..05H in 0.375 dB, below is mute
// - Pair A link makes left code drive both
// - Pair B link makes left code drive both
// - Full ramp takes 236/fs or 944/fs
// - Mute ramps down to -72 dB first
// - Codes kept while powered down, used after init
// - Level control starts from pair left code
// - Level control starts within recovery wait time
// - Gain writes ignored while level control active
// - Quad enable rise starts both pairs from A left
// - Quad enable overrides pair enables
// - Quad clear gives manual; pair enables keep running
// - Software powers A then B, down reverse
// - Recovery wait is 128, 256, 512 or 1024/fs
`ifndef IVC_DEFS_SVH
`define IVC_DEFS_SVH
`define IVC_CLK_HZ      250000000
`define IVC_FS_HZ       48000
`define IVC_FS_DIV      (`IVC_CLK_HZ / `IVC_FS_HZ)
`define IVC_VOL_RST     8'h91
`define IVC_CODE_MIN    8'h05
`define IVC_POS_OFS     11'd188
`define IVC_POS_CODE_MIN 11'd208
`define IVC_POS_FLOOR   11'd0
`define IVC_STEP_SLOW   11'd1
`define IVC_STEP_FAST   11'd4
`define IVC_WAIT_BASE   11'd128
`define IVC_INIT_FS     8'd16
`define IVC_SEL_AL      2'd0
`define IVC_SEL_AR      2'd1
`define IVC_SEL_BL      2'd2
`define IVC_SEL_BR      2'd3
`endif

// *** rtl/ivc_pkg.sv ***
// Types of the input volume and level-control mode block
package ivc_pkg;
  typedef enum logic [1:0] {
    PS_MANUAL,
    PS_START,
    PS_ALC
  } ivc_pair_st_t;
  typedef logic [10:0] ivc_pos_t;
endpackage

// *** rtl/ivc_strm_if.sv ***
// Valid/ready word stream carried between the block's modules
`timescale 1ns/10ps
`default_nettype none
interface ivc_strm_if #(parameter int W = 26);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/ivc_fifo.sv ***
// Sample FIFO with parameterised width and depth
`timescale 1ns/10ps
`default_nettype none
module ivc_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  ivc_strm_if.snk   s_in,
  ivc_strm_if.src   s_out
);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          rdy_reg, rdy_next;
  logic          push, pop;

  always_comb begin
    push     = s_in.valid && rdy_reg;
    pop      = s_out.valid && s_out.ready;
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // Registered ready keeps the port off the pop path
    rdy_next = cnt_next < (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= s_in.data;
    end
  end

  assign s_in.ready  = rdy_reg;
  assign s_out.valid = cnt_reg != '0;
  assign s_out.data  = mem_reg[rd_reg];
endmodule
`default_nettype wire

// *** rtl/ivc_ramp.sv ***
// Per-channel soft gain ramp with power-up hold
`timescale 1ns/10ps
`default_nettype none
`include "ivc_defs.svh"
module ivc_ramp
  import ivc_pkg::*;
(
  input  wire logic     i_ref_clk,
  input  wire logic     i_rst_b,
  input  wire logic     i_fs_tick,
  input  wire logic     i_pwr,
  input  wire logic     i_fast,
  input  wire logic     i_load,
  input  wire ivc_pos_t i_target,
  output ivc_pos_t      o_pos,
  output logic          o_at_target,
  output logic          o_ready
);
  ivc_pos_t   pos_reg, pos_next, step;
  logic [7:0] init_reg, init_next;

  always_comb begin
    step      = i_fast ? `IVC_STEP_FAST : `IVC_STEP_SLOW;
    pos_next  = pos_reg;
    init_next = init_reg;
    if (!i_pwr) begin
      // Gain follows the stored code so it starts there after power-up
      pos_next  = i_target;
      init_next = '0;
    end else if (init_reg != `IVC_INIT_FS) begin
      pos_next  = i_target;
      init_next = i_fs_tick ? 8'(init_reg + 1'b1) : init_reg;
    end else if (i_load) begin
      pos_next  = i_target;
    end else if (i_fs_tick) begin
      // Target re-read every tick, so a new code retargets at once
      if (pos_reg < i_target) begin
        pos_next = (i_target - pos_reg > step) ? ivc_pos_t'(pos_reg + step) : i_target;
      end else if (pos_reg > i_target) begin
        pos_next = (pos_reg - i_target > step) ? ivc_pos_t'(pos_reg - step) : i_target;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_reg  <= ivc_pos_t'({`IVC_VOL_RST, 2'b00}) + `IVC_POS_OFS;
      init_reg <= '0;
    end else begin
      pos_reg  <= pos_next;
      init_reg <= init_next;
    end
  end

  assign o_pos       = pos_reg;
  assign o_at_target = pos_reg == i_target;
  assign o_ready     = init_reg == `IVC_INIT_FS;
endmodule
`default_nettype wire

// *** rtl/ivc_top.sv ***
// Input volume stage with manual, pair-linked and quad-linked level control modes
`timescale 1ns/10ps
`default_nettype none
`include "ivc_defs.svh"
module ivc_top
  import ivc_pkg::*;
#(
  parameter int DW     = 24,
  parameter int DEPTH  = 16,
  parameter int FS_DIV = `IVC_FS_DIV
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_vol_wr_en,
  input  wire logic [1:0]    i_vol_wr_sel,
  input  wire logic [7:0]    i_vol_wr_data,
  input  wire logic          i_vol_link_pair_a,
  input  wire logic          i_vol_link_pair_b,
  input  wire logic          i_vol_ramp_time_sel,
  input  wire logic          i_lvl_ctrl_en_pair_a,
  input  wire logic          i_lvl_ctrl_en_pair_b,
  input  wire logic          i_lvl_ctrl_quad_link_en,
  input  wire logic [1:0]    i_recovery_wait_sel,
  input  wire logic          i_pwr_adc_a_left,
  input  wire logic          i_pwr_adc_a_right,
  input  wire logic          i_pwr_adc_b_left,
  input  wire logic          i_pwr_adc_b_right,
  input  wire logic [7:0]    i_alc_gain_a,
  input  wire logic [7:0]    i_alc_gain_b,
  input  wire logic          i_smp_valid,
  input  wire logic [1:0]    i_smp_chan,
  input  wire logic [DW-1:0] i_smp_data,
  output logic               o_smp_ready,
  input  wire logic          i_out_ready,
  output logic               o_out_valid,
  output logic [1:0]         o_out_chan,
  output logic [DW-1:0]      o_out_data,
  output logic [7:0]         o_out_gain_code,
  output logic               o_out_muted,
  output logic [1:0]         o_lvl_ctrl_active,
  output logic [7:0]         o_alc_start_code_a,
  output logic [7:0]         o_alc_start_code_b,
  output logic [10:0]        o_recovery_wait_len,
  output logic [3:0][7:0]    o_vol_code
);
  localparam int FW = DW + 2;
  localparam int CW = $clog2(FS_DIV);

  // Gain code to ramp position in 0.09375 dB units; mute codes aim at -72 dB
  function automatic ivc_pos_t code_to_pos(input logic [7:0] code);
    if (code < `IVC_CODE_MIN) begin
      code_to_pos = `IVC_POS_FLOOR;
    end else begin
      code_to_pos = ivc_pos_t'({code, 2'b00}) + `IVC_POS_OFS;
    end
  endfunction

  function automatic logic [7:0] pos_to_code(input ivc_pos_t pos);
    ivc_pos_t d;
    d = pos - `IVC_POS_OFS;
    pos_to_code = (pos >= `IVC_POS_CODE_MIN) ? d[9:2] : 8'h00;
  endfunction

  // Sample-rate enable from the reference clock
  logic [CW-1:0] div_reg, div_next;
  logic          tick_reg, tick_next;

  always_comb begin
    tick_next = div_reg == CW'(FS_DIV - 1);
    div_next  = tick_next ? '0 : CW'(div_reg + 1'b1);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // Pair mode control
  ivc_pair_st_t st_reg [2];
  ivc_pair_st_t st_next [2];
  logic [10:0]  wait_reg [2];
  logic [10:0]  wait_next [2];
  logic [7:0]   vol_reg [4];
  logic [7:0]   vol_next [4];
  logic [1:0]   act_reg, act_next;
  logic [7:0]   start_reg [2];
  logic [7:0]   start_next [2];
  logic [10:0]  wait_len;
  logic [1:0]   eff_en, quad_rise;
  logic         quad_d_reg;
  logic [3:0]   pwr, at_tgt, rdy, load;
  ivc_pos_t     tgt [4];
  ivc_pos_t     pos [4];

  always_comb begin
    wait_len  = `IVC_WAIT_BASE << i_recovery_wait_sel;
    // Quad link overrides both pair enables
    eff_en    = i_lvl_ctrl_quad_link_en ? 2'b11
              : {i_lvl_ctrl_en_pair_b, i_lvl_ctrl_en_pair_a};
    quad_rise = {2{i_lvl_ctrl_quad_link_en && !quad_d_reg}};
    // Each channel powers on its own; pair order is left to software
    pwr       = {i_pwr_adc_b_right, i_pwr_adc_b_left,
                 i_pwr_adc_a_right, i_pwr_adc_a_left};
    for (int p = 0; p < 2; p++) begin
      st_next[p]    = st_reg[p];
      wait_next[p]  = wait_reg[p];
      act_next[p]   = 1'b0;
      // Quad start gain is always pair A left, else the pair's own left
      start_next[p] = i_lvl_ctrl_quad_link_en ? vol_reg[`IVC_SEL_AL]
                    : vol_reg[2*p];
      case (st_reg[p])
        PS_MANUAL: begin
          wait_next[p] = '0;
          if ((eff_en[p] || quad_rise[p]) && rdy[2*p] && rdy[2*p+1]) begin
            st_next[p] = PS_START;
          end
        end
        PS_START: begin
          act_next[p] = 1'b1;
          if (!eff_en[p]) begin
            st_next[p] = PS_MANUAL;
          end else if ((at_tgt[2*p] && at_tgt[2*p+1]) || wait_reg[p] >= wait_len) begin
            // Never later than the recovery wait
            st_next[p] = PS_ALC;
          end else if (tick_reg) begin
            wait_next[p] = 11'(wait_reg[p] + 1'b1);
          end
        end
        PS_ALC: begin
          act_next[p]  = 1'b1;
          // Count cleared so the reported wait covers START only
          wait_next[p] = '0;
          // Pair enables set before quad clears keep the pair running
          if (!eff_en[p]) begin
            st_next[p] = PS_MANUAL;
          end
        end
        default: st_next[p] = PS_MANUAL;
      endcase
    end
    for (int c = 0; c < 4; c++) begin
      vol_next[c] = vol_reg[c];
      // Writes land while powered down too, so the code is kept
      if (i_vol_wr_en && i_vol_wr_sel == 2'(c) && st_reg[c/2] == PS_MANUAL) begin
        vol_next[c] = i_vol_wr_data;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < 2; p++) begin
        st_reg[p]    <= PS_MANUAL;
        wait_reg[p]  <= '0;
        start_reg[p] <= `IVC_VOL_RST;
      end
      for (int c = 0; c < 4; c++) begin
        vol_reg[c] <= `IVC_VOL_RST;
      end
      act_reg    <= '0;
      quad_d_reg <= 1'b0;
    end else begin
      st_reg     <= st_next;
      wait_reg   <= wait_next;
      start_reg  <= start_next;
      vol_reg    <= vol_next;
      act_reg    <= act_next;
      quad_d_reg <= i_lvl_ctrl_quad_link_en;
    end
  end

  // Ramp targets per channel
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      load[c] = 1'b0;
      case (st_reg[c/2])
        PS_START: tgt[c] = code_to_pos(start_reg[c/2]);
        PS_ALC: begin
          // Level-control engine gain is applied directly
          tgt[c]  = code_to_pos((c < 2 || i_lvl_ctrl_quad_link_en) ? i_alc_gain_a
                                                                   : i_alc_gain_b);
          load[c] = 1'b1;
        end
        default: begin
          tgt[c] = code_to_pos(vol_reg[c]);
          if (c == 1 && i_vol_link_pair_a) begin
            tgt[c] = code_to_pos(vol_reg[`IVC_SEL_AL]);
          end
          if (c == 3 && i_vol_link_pair_b) begin
            tgt[c] = code_to_pos(vol_reg[`IVC_SEL_BL]);
          end
        end
      endcase
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_ramp
    ivc_ramp u_ramp (
      .i_ref_clk   (i_ref_clk),
      .i_rst_b     (i_rst_b),
      .i_fs_tick   (tick_reg),
      .i_pwr       (pwr[g]),
      .i_fast      (!i_vol_ramp_time_sel),
      .i_load      (load[g]),
      .i_target    (tgt[g]),
      .o_pos       (pos[g]),
      .o_at_target (at_tgt[g]),
      .o_ready     (rdy[g])
    );
  end

  // Sample path through the FIFO
  ivc_strm_if #(.W(FW)) s_in ();
  ivc_strm_if #(.W(FW)) s_out ();

  assign s_in.valid = i_smp_valid;
  assign s_in.data  = {i_smp_chan, i_smp_data};
  assign o_smp_ready = s_in.ready;

  ivc_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .s_in      (s_in),
    .s_out     (s_out)
  );

  logic          ov_reg, ov_next, om_reg, om_next;
  logic [1:0]    oc_reg, oc_next;
  logic [DW-1:0] od_reg, od_next;
  logic [7:0]    og_reg, og_next;
  logic [3:0][7:0] vc_reg, vc_next;
  logic [1:0]    pop_ch;

  always_comb begin
    pop_ch       = s_out.data[FW-1:DW];
    s_out.ready  = !ov_reg || i_out_ready;
    ov_next      = ov_reg;
    oc_next      = oc_reg;
    od_next      = od_reg;
    og_next      = og_reg;
    om_next      = om_reg;
    if (s_out.ready) begin
      ov_next = s_out.valid;
      if (s_out.valid) begin
        oc_next = pop_ch;
        og_next = pos_to_code(pos[pop_ch]);
        // Mute only once the ramp has reached the floor
        om_next = pos[pop_ch] == `IVC_POS_FLOOR;
        od_next = om_next ? '0 : s_out.data[DW-1:0];
      end
    end
    for (int c = 0; c < 4; c++) begin
      vc_next[c] = pos_to_code(pos[c]);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ov_reg <= 1'b0;
      oc_reg <= '0;
      od_reg <= '0;
      og_reg <= `IVC_VOL_RST;
      om_reg <= 1'b0;
      vc_reg <= {4{`IVC_VOL_RST}};
    end else begin
      ov_reg <= ov_next;
      oc_reg <= oc_next;
      od_reg <= od_next;
      og_reg <= og_next;
      om_reg <= om_next;
      vc_reg <= vc_next;
    end
  end

  assign o_out_valid         = ov_reg;
  assign o_out_chan          = oc_reg;
  assign o_out_data          = od_reg;
  assign o_out_gain_code     = og_reg;
  assign o_out_muted         = om_reg;
  assign o_lvl_ctrl_active   = act_reg;
  assign o_alc_start_code_a  = start_reg[0];
  assign o_alc_start_code_b  = start_reg[1];
  assign o_recovery_wait_len = wait_reg[0] | wait_reg[1];
  assign o_vol_code          = vc_reg;
endmodule
`default_nettype wire

// *** verif/ivc_top_monitor.sv ***
// Port-level assertions for the input volume block
`timescale 1ns/10ps
`default_nettype none
module ivc_top_monitor #(
  parameter int DW     = 24,
  parameter int DEPTH  = 16,
  parameter int FS_DIV = 4
) (
  input wire logic             i_ref_clk,
  input wire logic             i_rst_b,
  input wire logic             i_out_ready,
  input wire logic             i_lvl_ctrl_en_pair_a,
  input wire logic             i_lvl_ctrl_quad_link_en,
  input wire logic [1:0]       i_recovery_wait_sel,
  input wire logic             i_pwr_adc_a_left,
  input wire logic             i_pwr_adc_a_right,
  input wire logic             o_out_valid,
  input wire logic [1:0]       o_out_chan,
  input wire logic [DW-1:0]    o_out_data,
  input wire logic             o_out_muted,
  input wire logic [1:0]       o_lvl_ctrl_active,
  input wire logic [7:0]       o_alc_start_code_a,
  input wire logic [7:0]       o_alc_start_code_b,
  input wire logic [10:0]      o_recovery_wait_len,
  input wire logic [3:0][7:0]  o_vol_code
);
  logic eff_a;
  assign eff_a = i_lvl_ctrl_quad_link_en | i_lvl_ctrl_en_pair_a;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_out_hold: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data) && $stable(o_out_chan))
    else $error("output word changed while stalled");
  a_muted_zero: assert property (
    o_out_valid && o_out_muted |-> o_out_data == '0)
    else $error("muted sample carries data");
  a_quad_start: assert property (
    i_lvl_ctrl_quad_link_en && o_lvl_ctrl_active == 2'h3 |-> o_alc_start_code_a == o_alc_start_code_b)
    else $error("quad start codes differ");
  a_manual_none: assert property (
    (!eff_a)[*3] |=> !o_lvl_ctrl_active[0])
    else $error("pair A active without enable");
  a_active_within: assert property (
    $rose(eff_a) && i_pwr_adc_a_left && i_pwr_adc_a_right |-> ##[1:1000] o_lvl_ctrl_active[0])
    else $error("pair A level control did not start");
  a_ramp_step: assert property (
    (o_lvl_ctrl_active[0] == 1'b0)[*3] ##0 (i_pwr_adc_a_left && $past(i_pwr_adc_a_left)
    && o_vol_code[0] >= 8'h05 && $past(o_vol_code[0]) >= 8'h05)
    |-> 8'(o_vol_code[0] - $past(o_vol_code[0]) + 8'h01) <= 8'h02)
    else $error("gain jumped by more than one code");
  a_ramp_pace: assert property (
    (o_lvl_ctrl_active[0] == 1'b0)[*3] ##0 (FS_DIV > 1 && i_pwr_adc_a_right
    && $past(i_pwr_adc_a_right) && $changed(o_vol_code[1])) |=> $stable(o_vol_code[1]))
    else $error("gain moved on two cycles in a row");
  a_wait_zero: assert property (
    (o_lvl_ctrl_active == 2'h0)[*3] |-> o_recovery_wait_len == 11'h000)
    else $error("wait count outside start");
  a_wait_bound: assert property (
    o_lvl_ctrl_active != 2'h0 |-> o_recovery_wait_len <= (11'h080 << i_recovery_wait_sel))
    else $error("wait count beyond selected limit");
  c_quad: cover property (i_lvl_ctrl_quad_link_en && o_lvl_ctrl_active == 2'h3);
  c_mute: cover property (o_out_valid && o_out_muted);
  c_wait: cover property (o_recovery_wait_len != 11'h000);
endmodule
bind ivc_top ivc_top_monitor #(.DW(DW), .DEPTH(DEPTH), .FS_DIV(FS_DIV)) u_mon (.*);
`default_nettype wire

// *** verif/ivc_adc_model.sv ***
// Far side model: sample source and stalling output sink
`timescale 1ns/10ps
`default_nettype none
module ivc_adc_model (
  input  wire logic   i_ref_clk,
  input  wire logic   i_slow,
  input  wire logic   i_stall,
  input  wire logic   i_smp_ready,
  output logic        o_smp_valid = '0,
  output logic [1:0]  o_smp_chan = '0,
  output logic [23:0] o_smp_data = '0,
  output logic        o_out_ready = '1
);
  always @(posedge i_ref_clk) begin
    o_out_ready <= !i_stall && (!i_slow || $urandom_range(1, 0) == 1);
  end
  // Holds the word until taken; gives up after 8 edges
  task automatic send(input logic [1:0] c, input logic [23:0] d, output logic ok);
    int n;
    o_smp_valid <= '1;
    o_smp_chan <= c;
    o_smp_data <= d;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (!i_smp_ready && n < 8);
    ok = i_smp_ready;
  endtask
  // Released lines show garbage, not the last word
  task automatic idle();
    o_smp_valid <= '0;
    o_smp_chan <= ~o_smp_chan;
    o_smp_data <= ~o_smp_data;
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the input volume block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ivc_pkg::*;
  typedef struct packed {
    logic [1:0]  c;
    logic [23:0] d;
    logic [7:0]  g;
    logic        m;
  } ivc_exp_t;
  logic i_ref_clk = 0, i_rst_b = 0, i_vol_wr_en = 0, i_vol_link_pair_a = 0;
  logic i_vol_link_pair_b = 0, i_vol_ramp_time_sel = 1, i_lvl_ctrl_en_pair_a = 0;
  logic i_lvl_ctrl_en_pair_b = 0, i_lvl_ctrl_quad_link_en = 0, i_pwr_adc_a_left = 0;
  logic i_pwr_adc_a_right = 0, i_pwr_adc_b_left = 0, i_pwr_adc_b_right = 0;
  logic i_smp_valid, i_out_ready, o_smp_ready, o_out_valid, o_out_muted, slow = 0, stall = 0;
  logic [1:0] i_vol_wr_sel = 0, i_recovery_wait_sel = 0, i_smp_chan, o_out_chan;
  logic [1:0] o_lvl_ctrl_active;
  logic [7:0] i_vol_wr_data = 0, i_alc_gain_a = 8'h91, i_alc_gain_b = 8'h91;
  logic [7:0] o_out_gain_code, o_alc_start_code_a, o_alc_start_code_b;
  logic [23:0] i_smp_data, o_out_data;
  logic [10:0] o_recovery_wait_len;
  logic [3:0][7:0] o_vol_code;
  logic [7:0] ecode [4] = '{4{8'h91}};
  logic [3:0] emute = 0;
  ivc_exp_t q[$];
  int fail_count = 0, comparisons = 0, n, acc;
  // Small fs divider keeps ramps short
  ivc_top #(.FS_DIV(4)) DUT (.*);
  ivc_adc_model u_far (.i_ref_clk, .i_slow(slow), .i_stall(stall), .i_smp_ready(o_smp_ready),
    .o_smp_valid(i_smp_valid), .o_smp_chan(i_smp_chan), .o_smp_data(i_smp_data),
    .o_out_ready(i_out_ready));
  initial forever #2 i_ref_clk = ~i_ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  task automatic chk(input logic [34:0] g, input logic [34:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_code(input logic [1:0] s, input logic [7:0] d);
    i_vol_wr_en <= '1;
    i_vol_wr_sel <= s;
    i_vol_wr_data <= d;
    tick(1);
    i_vol_wr_en <= '0;
    tick(1);
  endtask
  task automatic wcode(input int i, input logic [7:0] c);
    n = 0;
    for (; o_vol_code[i] !== c && n < 3000; n++) tick(1);
    chk(o_vol_code[i], c);
  endtask
  task automatic wact(input logic [1:0] m);
    n = 0;
    for (; o_lvl_ctrl_active !== m && n < 1500; n++) tick(1);
    chk(o_lvl_ctrl_active, m);
  endtask
  task automatic burst(input int k, input logic only3);
    logic ok;
    logic [1:0] c;
    acc = 0;
    for (int j = 0; j < k; j++) begin
      c = only3 ? 2'h3 : 2'($urandom % 3);
      if (c == 2'h1) c = 2'h3;
      u_far.send(c, 24'($urandom), ok);
      if (!ok) break;
      acc++;
    end
    u_far.idle();
  endtask
  task automatic drain();
    n = 0;
    for (; q.size() != 0 && n < 400; n++) tick(1);
    chk(q.size(), 0);
  endtask
  // Expected words noted at acceptance, compared when they leave
  always @(posedge i_ref_clk) begin
    if (i_smp_valid && o_smp_ready)
      q.push_back({i_smp_chan, emute[i_smp_chan] ? 24'h0 : i_smp_data, ecode[i_smp_chan],
        emute[i_smp_chan]});
    if (o_out_valid && i_out_ready)
      chk({o_out_chan, o_out_data, o_out_gain_code, o_out_muted}, q.size() ? q.pop_front() : '1);
  end
  initial begin
    tick(60000);
    fail_count++;
    summarize();
  end
  initial begin
    n = $urandom(32'hb31aea41);
    tick(2);
    i_rst_b <= '1;
    tick(1);
    for (int i = 0; i < 4; i++) chk(o_vol_code[i], 8'h91);
    chk({o_alc_start_code_a, o_alc_start_code_b, o_lvl_ctrl_active, o_smp_ready}, 19'h48c89);
    wr_code(2'h1, 8'h95);
    {i_pwr_adc_a_left, i_pwr_adc_a_right} <= 2'h3;
    tick(4);
    {i_pwr_adc_b_left, i_pwr_adc_b_right} <= 2'h3;
    wcode(1, 8'h95);
    slow <= '1;
    burst(12, '0);
    drain();
    stall <= '1;
    burst(24, '0);
    chk(acc >= 16 && !o_smp_ready, 1);
    stall <= '0;
    drain();
    i_vol_ramp_time_sel <= '0;
    wr_code(2'h0, 8'hf1);
    wcode(0, 8'hf1);
    chk(n inside {[370:400]}, 1);
    i_vol_ramp_time_sel <= '1;
    wr_code(2'h0, 8'he9);
    wcode(0, 8'he9);
    // Shown code floors, so a falling ramp shows it three steps early
    chk(n inside {[112:120]}, 1);
    i_vol_ramp_time_sel <= '0;
    wr_code(2'h0, 8'hf1);
    tick(20);
    chk(o_vol_code[0] inside {[8'hea:8'hf0]}, 1);
    wr_code(2'h0, 8'h91);
    wcode(0, 8'h91);
    i_vol_link_pair_a <= '1;
    wcode(1, 8'h91);
    i_vol_link_pair_a <= '0;
    wcode(1, 8'h95);
    wr_code(2'h2, 8'h81);
    wcode(2, 8'h81);
    wr_code(2'h3, 8'ha1);
    wcode(3, 8'ha1);
    i_vol_link_pair_b <= '1;
    wcode(3, 8'h81);
    i_vol_link_pair_b <= '0;
    wcode(3, 8'ha1);
    wr_code(2'h3, 8'h00);
    wcode(3, 8'h00);
    tick(240);
    ecode[3] = 8'h00;
    emute[3] = '1;
    burst(4, '1);
    drain();
    i_alc_gain_a <= 8'($urandom_range(241, 5));
    i_alc_gain_b <= 8'($urandom_range(241, 5));
    i_lvl_ctrl_en_pair_a <= '1;
    wact(2'h1);
    chk(o_alc_start_code_a, 8'h91);
    wr_code(2'h0, 8'hc1);
    i_lvl_ctrl_en_pair_a <= '0;
    wact(2'h0);
    wcode(0, 8'h91);
    wcode(1, 8'h95);
    tick(1000);
    wr_code(2'h0, 8'ha5);
    i_lvl_ctrl_quad_link_en <= '1;
    wact(2'h3);
    chk({o_alc_start_code_a, o_alc_start_code_b}, 16'ha5a5);
    {i_lvl_ctrl_en_pair_a, i_lvl_ctrl_en_pair_b} <= 2'h3;
    tick(20);
    chk(o_lvl_ctrl_active, 2'h3);
    i_lvl_ctrl_quad_link_en <= '0;
    tick(20);
    chk(o_lvl_ctrl_active, 2'h3);
    {i_lvl_ctrl_en_pair_a, i_lvl_ctrl_en_pair_b} <= 2'h0;
    wact(2'h0);
    tick(1000);
    i_lvl_ctrl_quad_link_en <= '1;
    wact(2'h3);
    i_lvl_ctrl_quad_link_en <= '0;
    wact(2'h0);
    for (int k = 0; k < 4; k++) begin
      i_recovery_wait_sel <= 2'(k);
      tick(1000);
      i_lvl_ctrl_en_pair_b <= '1;
      wact(2'h2);
      tick(600);
      i_lvl_ctrl_en_pair_b <= '0;
      wact(2'h0);
    end
    {i_pwr_adc_b_left, i_pwr_adc_b_right} <= 2'h0;
    tick(4);
    {i_pwr_adc_a_left, i_pwr_adc_a_right} <= 2'h0;
    tick(4);
    summarize();
  end
endmodule
`default_nettype wire
